// File: common/qos_pkg.sv
// package: register map, field layout and frame constants of the qos block
package qos_pkg;
	// register groups (paddr[7:4]) and single addresses
	localparam logic [3:0]  GRP_CTRL       = 4'h0;
	localparam logic [3:0]  GRP_TAG        = 4'h1;
	localparam logic [3:0]  GRP_WEIGHT     = 4'h2;
	localparam logic [3:0]  GRP_DSCP       = 4'h4;
	localparam logic [7:0]  ADDR_TAG_MAP   = 8'h30;
	localparam logic [7:0]  ADDR_GLOBAL    = 8'h34;
	localparam logic [7:0]  ADDR_STATUS    = 8'h50;
	// per-port control word fields, then global and default tag field offsets
	localparam int          CTRL_SPLIT_LO  = 0;
	localparam int          CTRL_REMOVE    = 1;
	localparam int          CTRL_INSERT    = 2;
	localparam int          CTRL_PPRIO_LO  = 3;
	localparam int          CTRL_TAG_EN    = 5;
	localparam int          CTRL_DSCP_EN   = 6;
	localparam int          CTRL_CEIL      = 7;
	localparam int          CTRL_SPLIT_HI  = 8;
	localparam int          CTRL_WFQ       = 9;
	localparam int          CTRL_SRC_LO    = 12;
	localparam int          MAP2Q_LO       = 6;
	localparam int          TCI_PCP_LO     = 13;
	// reset values and the weight write mask
	localparam logic [15:0] CTRL_RST       = 16'h0000;
	localparam logic [15:0] TAG_RST        = 16'h0000;
	localparam logic [31:0] WEIGHT_RST     = 32'h08040201;
	localparam logic [31:0] WEIGHT_MASK    = 32'h7f7f7f7f;
	localparam logic [15:0] TAG_MAP_RST    = 16'hfa50;
	localparam logic [7:0]  GLOBAL_RST     = 8'h80;
	// frame layout (byte index, frame without fcs)
	localparam logic [4:0]  OFS_TYPE_HI    = 5'h0c;
	localparam logic [4:0]  OFS_TYPE_LO    = 5'h0d;
	localparam logic [4:0]  OFS_TCI_HI     = 5'h0e;
	localparam logic [4:0]  OFS_TCI_LO     = 5'h0f;
	localparam logic [4:0]  OFS_TOS_UNTAG  = 5'h0f;
	localparam logic [4:0]  OFS_INNER_HI   = 5'h10;
	localparam logic [4:0]  OFS_INNER_LO   = 5'h11;
	localparam logic [4:0]  OFS_TOS_TAG    = 5'h13;
	localparam logic [4:0]  CNT_MAX        = 5'h1f;
	localparam logic [15:0] TPID           = 16'h8100;
	localparam logic [15:0] ETH_IPV4       = 16'h0800;
	localparam logic [31:0] CRC_POLY       = 32'hedb88320;
	localparam logic [31:0] CRC_INIT       = 32'hffffffff;

	typedef enum logic [1:0] {
		QM_ONE  = 2'h0,
		QM_TWO  = 2'h1,
		QM_FOUR = 2'h2
	} queue_mode_t;

	typedef enum logic [2:0] {
		ED_HDR  = 3'h0,
		ED_HOLD = 3'h1,
		ED_TAIL = 3'h3,
		ED_BODY = 3'h2,
		ED_FCS  = 3'h6,
		ED_INS  = 3'h7,
		ED_DROP = 3'h5
	} edit_state_t;
endpackage : qos_pkg

// File: rtl/qos_priority_tagging.sv
// qos classifier, egress queue scheduler and vlan tag editor with its fifo
`timescale 1ns/1ps
`default_nettype none

module qos_stream_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk_sys,   // core clock
	input  wire logic                     rst_b,     // sync reset, active low
	input  wire logic                     in_valid,  // write request
	output logic                          in_ready,  // room for a word
	input  wire logic [WIDTH-1:0]         in_data,   // write word
	output logic                          out_valid, // word available
	input  wire logic                     out_ready, // read accept
	output logic [WIDTH-1:0]              out_data,  // head word
	output logic [$clog2(DEPTH):0]        level      // words held
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("fifo depth must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;
	wire [AW:0]       next_level = level + (AW+1)'(push) - (AW+1)'(pop);

	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// flags registered so the ports come straight from flops
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			level     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_ptr    <= wr_ptr + AW'(push);
			rd_ptr    <= rd_ptr + AW'(pop);
			level     <= next_level;
			in_ready  <= next_level != (AW+1)'(DEPTH);
			out_valid <= next_level != '0;
		end
	end
endmodule : qos_stream_fifo

module qos_priority_tagging #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic        clk_sys,     // core clock, 100 MHz
	input  wire logic        rst_b,       // sync reset, active low
	input  wire logic [7:0]  paddr,       // apb byte address
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb direction
	input  wire logic [31:0] pwdata,      // apb write data
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error, unmapped address
	input  wire logic        ing_valid,   // ingress byte valid
	input  wire logic [7:0]  ing_data,    // ingress byte
	input  wire logic        ing_sop,     // first byte of packet
	input  wire logic        ing_eop,     // last byte of packet
	input  wire logic [1:0]  ing_src,     // ingress port, at sop
	input  wire logic [1:0]  ing_dst,     // egress port, at sop
	output logic             cls_valid,   // classification result pulse
	output logic      [1:0]  cls_port,    // egress port of the packet
	output logic      [1:0]  cls_queue,   // egress queue to use
	output logic      [1:0]  cls_prio,    // packet priority level
	input  wire logic        sch_req,     // scheduling request pulse
	input  wire logic [1:0]  sch_port,    // egress port to schedule
	input  wire logic [3:0]  sch_pending, // non-empty queues of that port
	output logic             gnt_valid,   // grant pulse
	output logic      [1:0]  gnt_queue,   // queue granted
	input  wire logic        eg_valid,    // egress byte valid
	output logic             eg_ready,    // egress fifo has room
	input  wire logic [7:0]  eg_data,     // egress byte, no fcs
	input  wire logic        eg_sop,      // first byte
	input  wire logic        eg_eop,      // last byte before fcs
	input  wire logic [1:0]  eg_src,      // ingress port of packet
	input  wire logic [1:0]  eg_dst,      // egress port of packet
	output logic             tx_valid,    // edited byte valid
	input  wire logic        tx_ready,    // mac accepts byte
	output logic      [7:0]  tx_data,     // edited byte
	output logic             tx_sop,      // first byte
	output logic             tx_eop       // last fcs byte
);
	localparam int FW = 14;
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ qos_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	logic [15:0]  port_ctrl [4];
	logic [15:0]  def_tag [4];
	logic [31:0]  weight [4];
	logic [15:0]  tag_map;
	logic [7:0]   glob;
	logic [127:0] dscp_map;
	logic [6:0]   credit [4][4];

	// register bus
	wire [1:0]  rp       = paddr[3:2];
	wire        aligned  = paddr[1:0] == 2'h0;
	wire        sel_ctrl = aligned && paddr[7:4] == qos_pkg::GRP_CTRL;
	wire        sel_tag  = aligned && paddr[7:4] == qos_pkg::GRP_TAG;
	wire        sel_wt   = aligned && paddr[7:4] == qos_pkg::GRP_WEIGHT;
	wire        sel_dscp = aligned && paddr[7:4] == qos_pkg::GRP_DSCP;
	wire        sel_map  = paddr == qos_pkg::ADDR_TAG_MAP;
	wire        sel_glob = paddr == qos_pkg::ADDR_GLOBAL;
	wire        sel_stat = paddr == qos_pkg::ADDR_STATUS;
	wire        hit      = sel_ctrl | sel_tag | sel_wt | sel_dscp | sel_map | sel_glob | sel_stat;
	wire        acc      = psel && penable;
	wire        wr_fire  = acc && pready && pwrite && hit;
	logic [2:0]    ed_st_bits;
	logic [LW-1:0] f_level;
	wire [31:0] status   = {13'h0, ed_st_bits, 16'(f_level)};
	wire [31:0] rd_data  = sel_ctrl ? {16'h0, port_ctrl[rp]} :
	                       sel_tag  ? {16'h0, def_tag[rp]} :
	                       sel_wt   ? weight[rp] :
	                       sel_dscp ? dscp_map[{rp, 5'h00} +: 32] :
	                       sel_map  ? {16'h0, tag_map} :
	                       sel_glob ? {24'h0, glob} :
	                       sel_stat ? status : 32'h0;

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready)
				prdata <= rd_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			for (int p = 0; p < 4; p++)
			begin
				port_ctrl[p] <= qos_pkg::CTRL_RST;
				def_tag[p]   <= qos_pkg::TAG_RST;
				weight[p]    <= qos_pkg::WEIGHT_RST;
			end
			tag_map  <= qos_pkg::TAG_MAP_RST;
			glob     <= qos_pkg::GLOBAL_RST;
			dscp_map <= '0;
		end
		else if (wr_fire)
		begin
			if (sel_ctrl)
				port_ctrl[rp] <= pwdata[15:0];
			else if (sel_tag)
				def_tag[rp] <= pwdata[15:0];
			else if (sel_wt)
				weight[rp] <= pwdata & qos_pkg::WEIGHT_MASK;
			else if (sel_dscp)
				dscp_map[{rp, 5'h00} +: 32] <= pwdata;
			else if (sel_map)
				tag_map <= pwdata[15:0];
			else if (sel_glob)
				glob <= pwdata[7:0];
		end
	end

	// ingress classification, decided on the last byte
	logic [4:0] ing_cnt;
	logic [1:0] c_src;
	logic [1:0] c_dst;
	logic [7:0] c_type_hi;
	logic       c_tagged;
	logic       c_ip_untag;
	logic       c_ip_tag;
	logic [2:0] c_pcp;
	logic [7:0] c_tos;

	wire [4:0]  ing_idx   = ing_sop ? 5'h00 : ing_cnt;
	wire [4:0]  ing_inc   = (ing_idx == qos_pkg::CNT_MAX) ? ing_idx : ing_idx + 5'h01;
	wire [15:0] ing_type  = {c_type_hi, ing_data};
	wire [15:0] ictl      = port_ctrl[c_src];
	wire [2:0]  idef_pcp  = def_tag[c_src][qos_pkg::TCI_PCP_LO +: 3];
	wire [2:0]  pcp_cap   = (ictl[qos_pkg::CTRL_CEIL] && c_pcp > idef_pcp) ? idef_pcp : c_pcp;
	wire        c_ip      = c_tagged ? c_ip_tag : c_ip_untag;
	wire [1:0]  p_tag     = (ictl[qos_pkg::CTRL_TAG_EN] && c_tagged) ?
	                        tag_map[{pcp_cap, 1'b0} +: 2] : 2'h0;
	// tos may be the eop byte itself, so bypass the register then
	wire        tos_hit   = (ing_idx == qos_pkg::OFS_TOS_UNTAG && !c_tagged) ||
	                        (ing_idx == qos_pkg::OFS_TOS_TAG && c_tagged);
	wire [7:0]  tos_now   = tos_hit ? ing_data : c_tos;
	wire [1:0]  p_dscp    = (ictl[qos_pkg::CTRL_DSCP_EN] && c_ip) ?
	                        dscp_map[{tos_now[7:2], 1'b0} +: 2] : 2'h0;
	wire [1:0]  p_port    = ictl[qos_pkg::CTRL_PPRIO_LO +: 2];
	wire [1:0]  p_max1    = (p_tag > p_port) ? p_tag : p_port;
	wire [1:0]  prio      = (p_dscp > p_max1) ? p_dscp : p_max1;
	wire [15:0] dctl      = port_ctrl[c_dst];
	wire [1:0]  dqm       = {dctl[qos_pkg::CTRL_SPLIT_HI], dctl[qos_pkg::CTRL_SPLIT_LO]};
	wire        two_high  = prio >= glob[qos_pkg::MAP2Q_LO +: 2];
	wire [1:0]  queue     = (dqm == qos_pkg::QM_FOUR) ? prio :
	                        (dqm == qos_pkg::QM_TWO) ? {1'b0, two_high} : 2'h0;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			ing_cnt    <= 5'h00;
			c_src      <= 2'h0;
			c_dst      <= 2'h0;
			c_type_hi  <= 8'h00;
			c_tagged   <= 1'b0;
			c_ip_untag <= 1'b0;
			c_ip_tag   <= 1'b0;
			c_pcp      <= 3'h0;
			c_tos      <= 8'h00;
			cls_valid  <= 1'b0;
			cls_port   <= 2'h0;
			cls_queue  <= 2'h0;
			cls_prio   <= 2'h0;
		end
		else
		begin
			cls_valid <= ing_valid && ing_eop;
			if (ing_valid)
			begin
				ing_cnt <= ing_inc;
				if (ing_sop)
				begin
					c_src    <= ing_src;
					c_dst    <= ing_dst;
					c_tagged <= 1'b0;
					c_ip_tag <= 1'b0;
				end
				if (ing_idx == qos_pkg::OFS_TYPE_HI || ing_idx == qos_pkg::OFS_INNER_HI)
					c_type_hi <= ing_data;
				if (ing_idx == qos_pkg::OFS_TYPE_LO)
				begin
					c_tagged   <= ing_type == qos_pkg::TPID;
					c_ip_untag <= ing_type == qos_pkg::ETH_IPV4;
				end
				if (ing_idx == qos_pkg::OFS_INNER_LO && c_tagged)
					c_ip_tag <= ing_type == qos_pkg::ETH_IPV4;
				if (ing_idx == qos_pkg::OFS_TCI_HI && c_tagged)
					c_pcp <= ing_data[7:5];
				if (tos_hit)
					c_tos <= ing_data;
				if (ing_eop)
				begin
					cls_port  <= c_dst;
					cls_queue <= queue;
					cls_prio  <= prio;
				end
			end
		end
	end

	// egress scheduler: strict, or weighted by per-queue credit
	wire [15:0] sctl     = port_ctrl[sch_port];
	wire [1:0]  sqm      = {sctl[qos_pkg::CTRL_SPLIT_HI], sctl[qos_pkg::CTRL_SPLIT_LO]};
	wire [3:0]  s_active = (sqm == qos_pkg::QM_FOUR) ? 4'hf :
	                       (sqm == qos_pkg::QM_TWO) ? 4'h3 : 4'h1;
	wire [3:0]  s_pend   = sch_pending & s_active;
	wire        s_wfq    = sctl[qos_pkg::CTRL_WFQ] && sqm == qos_pkg::QM_FOUR;
	wire        s_grant  = sch_req && (|s_pend);
	logic [3:0] s_cred;
	logic [1:0] s_pick;
	logic [6:0] next_credit [4];
	wire        s_reload = s_wfq && !(|(s_pend & s_cred));
	wire [3:0]  s_cand   = (s_wfq && !s_reload) ? (s_pend & s_cred) : s_pend;

	always_comb
	begin
		s_pick = 2'h0;
		for (int q = 0; q < 4; q++)
		begin
			s_cred[q] = credit[sch_port][q] != 7'h00;
			if (s_cand[q])
				s_pick = 2'(q);
		end
	end

	// a queue that runs out of credit waits until every pending queue is spent
	always_comb
	begin
		for (int q = 0; q < 4; q++)
		begin
			next_credit[q] = s_reload ? weight[sch_port][q*8 +: 7] : credit[sch_port][q];
			if (s_pick == 2'(q) && next_credit[q] != 7'h00)
				next_credit[q] = next_credit[q] - 7'h01;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			gnt_valid <= 1'b0;
			gnt_queue <= 2'h0;
			for (int p = 0; p < 4; p++)
				for (int q = 0; q < 4; q++)
					credit[p][q] <= 7'h00;
		end
		else
		begin
			gnt_valid <= s_grant;
			if (s_grant)
				gnt_queue <= s_pick;
			if (s_grant && s_wfq)
				for (int q = 0; q < 4; q++)
					credit[sch_port][q] <= next_credit[q];
		end
	end

	// egress tag editor behind the fifo
	logic          f_valid;
	logic [FW-1:0] f_word;
	logic          f_pop;

	qos_stream_fifo #(
		.WIDTH (FW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.in_valid  (eg_valid),
		.in_ready  (eg_ready),
		.in_data   ({eg_src, eg_dst, eg_sop, eg_eop, eg_data}),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_word),
		.level     (f_level)
	);

	qos_pkg::edit_state_t ed_st;
	logic [4:0]  ed_cnt;
	logic [1:0]  ed_sub;
	logic [1:0]  e_src;
	logic [1:0]  e_dst;
	logic [7:0]  hold1;
	logic [7:0]  hold2;
	logic        e_tagged;
	logic        e_eop_held;
	logic [31:0] crc;
	logic        ed_emit;
	logic [7:0]  ed_byte;
	logic        ed_last;
	logic        consume;

	wire [1:0]  f_src     = f_word[13:12];
	wire [1:0]  f_dst     = f_word[11:10];
	wire        f_sop     = f_word[9];
	wire        f_eop     = f_word[8];
	wire [7:0]  f_byte    = f_word[7:0];
	wire        adv       = !tx_valid || tx_ready;
	wire [4:0]  e_idx     = f_sop ? 5'h00 : ed_cnt;
	wire [4:0]  e_inc     = (ed_cnt == qos_pkg::CNT_MAX) ? ed_cnt : ed_cnt + 5'h01;
	wire [15:0] ectl      = port_ctrl[e_dst];
	wire [15:0] sctl_e    = port_ctrl[e_src];
	wire [2:0]  edef_pcp  = def_tag[e_src][qos_pkg::TCI_PCP_LO +: 3];
	wire        ins_ok    = ectl[qos_pkg::CTRL_INSERT] && ectl[qos_pkg::CTRL_SRC_LO + e_src];
	wire        rem_ok    = ectl[qos_pkg::CTRL_REMOVE];
	wire        hold_tag  = {hold1, f_byte} == qos_pkg::TPID;
	wire [31:0] ins_word  = {qos_pkg::TPID, def_tag[e_src]};
	wire        cap_now   = e_tagged && ed_cnt == qos_pkg::OFS_TCI_HI &&
	                        sctl_e[qos_pkg::CTRL_CEIL] && f_byte[7:5] > edef_pcp;
	wire        ed_first  = ed_st == qos_pkg::ED_HDR && f_sop;
	wire [31:0] crc_next  = crc_step(ed_first ? qos_pkg::CRC_INIT : crc, ed_byte);

	assign ed_st_bits = ed_st;
	assign f_pop      = adv && consume;

	always_comb
	begin
		ed_emit = 1'b0;
		ed_byte = f_byte;
		ed_last = 1'b0;
		consume = 1'b0;
		case (ed_st)
			qos_pkg::ED_HDR:
			begin
				consume = f_valid;
				ed_emit = f_valid && e_idx != qos_pkg::OFS_TYPE_HI;
			end
			qos_pkg::ED_HOLD, qos_pkg::ED_DROP:
				consume = f_valid;
			qos_pkg::ED_INS:
			begin
				ed_emit = 1'b1;
				ed_byte = ins_word[{~ed_sub, 3'h0} +: 8];
			end
			qos_pkg::ED_TAIL:
			begin
				ed_emit = 1'b1;
				ed_byte = ed_sub[0] ? hold2 : hold1;
			end
			qos_pkg::ED_BODY:
			begin
				consume = f_valid;
				ed_emit = f_valid;
				if (cap_now)
					ed_byte = {edef_pcp, f_byte[4:0]};
			end
			qos_pkg::ED_FCS:
			begin
				ed_emit = 1'b1;
				ed_byte = ~crc[{ed_sub, 3'h0} +: 8];
				ed_last = ed_sub == 2'h3;
			end
			default:
				ed_emit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_sop   <= 1'b0;
			tx_eop   <= 1'b0;
			crc      <= qos_pkg::CRC_INIT;
		end
		else if (adv)
		begin
			tx_valid <= ed_emit;
			if (ed_emit)
			begin
				tx_data <= ed_byte;
				tx_sop  <= ed_first;
				tx_eop  <= ed_last;
				if (ed_st != qos_pkg::ED_FCS)
					crc <= crc_next;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			ed_st      <= qos_pkg::ED_HDR;
			ed_cnt     <= 5'h00;
			ed_sub     <= 2'h0;
			e_src      <= 2'h0;
			e_dst      <= 2'h0;
			hold1      <= 8'h00;
			hold2      <= 8'h00;
			e_tagged   <= 1'b0;
			e_eop_held <= 1'b0;
		end
		else if (adv)
		begin
			case (ed_st)
				qos_pkg::ED_HDR:
					if (f_valid)
					begin
						ed_cnt <= e_idx + 5'h01;
						ed_sub <= 2'h0;
						if (f_sop)
						begin
							e_src <= f_src;
							e_dst <= f_dst;
						end
						if (e_idx == qos_pkg::OFS_TYPE_HI)
						begin
							hold1 <= f_byte;
							ed_st <= qos_pkg::ED_HOLD;
						end
						else if (f_eop)
							ed_st <= qos_pkg::ED_FCS;
					end
				qos_pkg::ED_HOLD:
					if (f_valid)
					begin
						hold2      <= f_byte;
						e_tagged   <= hold_tag;
						e_eop_held <= f_eop;
						ed_cnt     <= qos_pkg::OFS_TCI_HI;
						if (hold_tag && rem_ok && !f_eop)
							ed_st <= qos_pkg::ED_DROP;
						else if (!hold_tag && ins_ok)
							ed_st <= qos_pkg::ED_INS;
						else
							ed_st <= qos_pkg::ED_TAIL;
					end
				qos_pkg::ED_INS:
				begin
					ed_sub <= ed_sub + 2'h1;
					if (ed_sub == 2'h3)
						ed_st <= qos_pkg::ED_TAIL;
				end
				qos_pkg::ED_TAIL:
				begin
					ed_sub <= ed_sub + 2'h1;
					if (ed_sub[0])
					begin
						ed_sub <= 2'h0;
						ed_st  <= e_eop_held ? qos_pkg::ED_FCS : qos_pkg::ED_BODY;
					end
				end
				qos_pkg::ED_DROP:
					if (f_valid)
					begin
						ed_cnt <= e_inc;
						if (f_eop)
							ed_st <= qos_pkg::ED_FCS;
						else if (ed_cnt == qos_pkg::OFS_TCI_LO)
							ed_st <= qos_pkg::ED_BODY;
					end
				qos_pkg::ED_BODY:
					if (f_valid)
					begin
						ed_cnt <= e_inc;
						if (f_eop)
							ed_st <= qos_pkg::ED_FCS;
					end
				qos_pkg::ED_FCS:
				begin
					ed_sub <= ed_sub + 2'h1;
					if (ed_sub == 2'h3)
						ed_st <= qos_pkg::ED_HDR;
				end
				default:
					ed_st <= qos_pkg::ED_HDR;
			endcase
		end
	end
endmodule : qos_priority_tagging

`default_nettype wire

// File: tb/qos_priority_tagging_chk.sv
// checker: handshake timing at the qos block ports
`timescale 1ns/1ps
`default_nettype none
module qos_priority_tagging_chk (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       ing_valid,
	input wire logic       ing_eop,
	input wire logic       cls_valid,
	input wire logic       sch_req,
	input wire logic [3:0] sch_pending,
	input wire logic       gnt_valid,
	input wire logic [1:0] gnt_queue,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic       tx_sop,
	input wire logic       tx_eop
);
	logic [3:0] last_pend;
	always_ff @(posedge clk_sys)
		last_pend <= sch_pending;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	chk_apb_wait: assert property ($rose(psel && penable) |-> s_wait ##1 pready)
		else $error("apb wait state wrong");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_cls_after: assert property (ing_valid && ing_eop |=> cls_valid)
		else $error("no result after eop");
	chk_cls_cause: assert property (cls_valid |-> $past(ing_valid && ing_eop))
		else $error("result without eop");
	chk_gnt_cause: assert property (gnt_valid |-> $past(sch_req) && last_pend[gnt_queue])
		else $error("grant of idle queue");
	chk_gnt_none: assert property (sch_req && sch_pending == 4'h0 |=> !gnt_valid)
		else $error("grant with none pending");
	chk_tx_hold: assert property (s_stall |=> tx_valid && $stable({tx_data, tx_sop, tx_eop}))
		else $error("tx byte dropped in stall");
	chk_tx_next: assert property (tx_valid && tx_ready && tx_eop |=> !tx_valid || tx_sop)
		else $error("frame not restarted");
endmodule : qos_priority_tagging_chk
bind qos_priority_tagging qos_priority_tagging_chk i_chk (.clk_sys, .rst_b, .psel, .penable,
	.pready, .pslverr, .ing_valid, .ing_eop, .cls_valid, .sch_req, .sch_pending, .gnt_valid,
	.gnt_queue, .tx_valid, .tx_ready, .tx_data, .tx_sop, .tx_eop);
`default_nettype wire

// File: tb/qos_mac_sink.sv
// partner: egress mac that stalls and collects edited bytes
`timescale 1ns/1ps
`default_nettype none
module qos_mac_sink (
	input  wire logic       clk_sys,  // core clock
	input  wire logic       rst_b,    // sync reset
	input  wire logic       hold,     // stall request
	input  wire logic       tx_valid, // byte offered
	output logic            tx_ready, // byte taken
	input  wire logic [7:0] tx_data,  // byte
	input  wire logic       tx_eop    // last byte
);
	logic [1:0] cnt;
	logic [7:0] rx_q[$];
	int         frames = 0;
	// one stall in four keeps the hold path busy; bench also clears rx_q
	always @(posedge clk_sys)
	begin
		cnt <= rst_b ? cnt + 2'h1 : 2'h0;
		tx_ready <= rst_b && !hold && cnt != 2'h3;
		if (tx_valid && tx_ready)
		begin
			rx_q.push_back(tx_data);
			frames <= frames + int'(tx_eop);
		end
	end
endmodule : qos_mac_sink
`default_nettype wire

// File: tb/qos_priority_tagging_tb_top.sv
// testbench: registers, classification, scheduling, tag editing
`timescale 1ns/1ps
`default_nettype none
module qos_priority_tagging_tb_top;
	logic        clk_sys = '0, rst_b = '0, psel = '0, penable = '0, pwrite = '0, hold = '0;
	logic        ing_valid = '0, ing_sop = '0, ing_eop = '0, sch_req = '0, eg_valid = '0;
	logic        eg_sop = '0, eg_eop = '0, pready, pslverr, cls_valid, gnt_valid, eg_ready;
	logic        tx_valid, tx_ready, tx_sop, tx_eop, er, refused = '0;
	logic [7:0]  paddr = '0, ing_data = '0, eg_data = '0, tx_data;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [1:0]  ing_src = '0, ing_dst = '0, sch_port = '0, eg_src = '0, eg_dst = '0;
	logic [1:0]  cls_port, cls_queue, cls_prio, gnt_queue;
	logic [3:0]  sch_pending = '0;
	int          fail_count = 0, n_checks = 0, cyc = 0;
	qos_priority_tagging #(.FIFO_DEPTH(4)) i_dut (.clk_sys, .rst_b, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .ing_valid, .ing_data, .ing_sop,
		.ing_eop, .ing_src, .ing_dst, .cls_valid, .cls_port, .cls_queue, .cls_prio, .sch_req,
		.sch_port, .sch_pending, .gnt_valid, .gnt_queue, .eg_valid, .eg_ready, .eg_data,
		.eg_sop, .eg_eop, .eg_src, .eg_dst, .tx_valid, .tx_ready, .tx_data, .tx_sop, .tx_eop);
	qos_mac_sink i_mac (.clk_sys, .rst_b, .hold, .tx_valid, .tx_ready, .tx_data, .tx_eop);
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	function automatic logic [7:0] fbyte(input int i, input logic t);
		if (i == 12)
			return t ? 8'h81 : 8'h08;
		if (i == 13 || (t && i == 17))
			return 8'h00;
		if (t && i == 14)
			return 8'he0;
		return (t && i == 16) ? 8'h08 : 8'(i);
	endfunction : fbyte
	function automatic logic [31:0] crc_of(input logic [7:0] q[$], input int n);
		logic [31:0] c = 32'hffffffff;
		for (int i = 0; i < n; i++)
		begin
			c ^= 32'(q[i]);
			repeat (8) c = c[0] ? (c >> 1) ^ qos_pkg::CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc_of
	task t_regs;
		apb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h08040201, "weights");
		apb(1'b0, 8'h30, 32'h0);
		chk(rd, 32'h0000fa50, "tag map");
		apb(1'b0, 8'h34, 32'h0);
		chk(rd, 32'h00000080, "global");
		apb(1'b1, 8'h1c, 32'h0000a00b);
		apb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0000a00b, "default tag");
		apb(1'b0, 8'h60, 32'h0);
		chk(32'(er), 32'h1, "unmapped");
		$display("test regs done");
	endtask : t_regs
	task t_class;
		logic [15:0] cc[8] = '{16'h0128, 16'h01a0, 16'h0100, 16'h0118, 16'h0021, 16'h00a1,
			16'h0140, 16'h0020};
		logic [3:0]  pq[8] = '{4'hf, 4'h5, 4'h0, 4'hf, 4'hd, 4'h4, 4'ha, 4'hc};
		apb(1'b1, 8'h18, 32'h00004000);
		apb(1'b1, 8'h40, 32'h00000200);
		ing_src <= 2'h2;
		ing_dst <= 2'h2;
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, 8'h08, 32'(cc[k]));
			for (int i = 0; i < 20; i++)
			begin
				ing_valid <= 1'b1;
				ing_data <= fbyte(i, 1'b1);
				ing_sop <= i == 0;
				ing_eop <= i == 19;
				@(posedge clk_sys);
			end
			ing_valid <= 1'b0;
			@(posedge clk_sys);
			chk(32'({cls_valid, cls_port}), 32'h6, "port");
			chk(32'(cls_queue), 32'(pq[k][1:0]), "queue");
			chk(32'(cls_prio), 32'(pq[k][3:2]), "prio");
		end
		$display("test class done");
	endtask : t_class
	task sched(input logic [1:0] p, input logic [3:0] pend, input logic [2:0] exp);
		sch_req <= 1'b1;
		sch_port <= p;
		sch_pending <= pend;
		@(posedge clk_sys);
		sch_req <= 1'b0;
		@(posedge clk_sys);
		chk(32'({gnt_valid, gnt_queue & {2{gnt_valid}}}), 32'(exp), "grant");
	endtask : sched
	task t_sched;
		apb(1'b1, 8'h00, 32'h00000100);
		apb(1'b1, 8'h04, 32'h00000300);
		sched(2'h0, 4'h5, 3'h6);
		sched(2'h0, 4'h3, 3'h5);
		sched(2'h0, 4'h0, 3'h0);
		sched(2'h2, 4'h3, 3'h4);
		for (int k = 0; k < 10; k++)
			sched(2'h1, 4'h9, k == 8 ? 3'h4 : 3'h7);
		$display("test sched done");
	endtask : t_sched
	task push(input logic t);
		for (int i = 0; i < (t ? 20 : 16); i++)
		begin
			eg_valid <= 1'b1;
			eg_data <= fbyte(i, t);
			eg_sop <= i == 0;
			eg_eop <= i == (t ? 19 : 15);
			@(posedge clk_sys);
			while (eg_ready !== 1'b1)
			begin
				refused = 1'b1;
				hold <= 1'b0;
				@(posedge clk_sys);
			end
		end
		eg_valid <= 1'b0;
	endtask : push
	task t_edit;
		logic [31:0] eb[4] = '{32'h81004000, 32'h8100400f, 32'h08001213, 32'h08000e0f};
		logic [7:0]  q[$];
		int          f, n;
		eg_src <= 2'h2;
		apb(1'b1, 8'h08, 32'h00000080);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, 8'h00, k < 2 ? 32'h00004004 : 32'h00000002);
			i_mac.rx_q.delete();
			f = i_mac.frames;
			hold <= k == 0;
			push(k == 1 || k == 2);
			while (i_mac.frames == f)
				@(posedge clk_sys);
			q = i_mac.rx_q;
			n = q.size() - 4;
			chk(32'(n), k < 2 ? 32'h14 : 32'h10, "length");
			chk({q[12], q[13], q[14], q[15]}, eb[k], "tag bytes");
			chk({q[n + 3], q[n + 2], q[n + 1], q[n]}, crc_of(q, n), "fcs");
		end
		chk(32'(refused), 32'h1, "fifo full");
		$display("test edit done");
	endtask : t_edit
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_class();
		t_sched();
		t_edit();
		wrap_up();
	end
endmodule : qos_priority_tagging_tb_top
`default_nettype wire
